// File: adp_pkg.sv
// Shared constants, codes and helpers for the converter output port and its capture end
`default_nettype none
package adp_pkg;

  // ------------------------------------------------------------
  // Clocking
  // ------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS  = 100;
  localparam int unsigned LINK_PERIOD_NS = 800;
  localparam int unsigned LINK_DIV       = LINK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned LINK_HALF      = LINK_DIV / 2;
  localparam logic [2:0]  DIV_LAST       = 3'(LINK_DIV - 1);
  localparam logic [2:0]  DIV_FALL       = 3'(LINK_HALF - 1);

  // ------------------------------------------------------------
  // Sample word
  // ------------------------------------------------------------
  localparam int unsigned DW       = 14;
  localparam int unsigned PAIRS    = DW / 2;
  localparam logic [13:0] CODE_MIN = 14'h0000;
  localparam logic [13:0] CODE_MAX = 14'h3FFF;

  // ------------------------------------------------------------
  // Device configuration map
  // ------------------------------------------------------------
  localparam logic [7:0]  PWR_ADDR    = 8'h6D;
  localparam logic [7:0]  PWR_RESET   = 8'h20;
  localparam int unsigned PWR_LSB     = 6;
  localparam logic [5:0]  PWR_FIXED   = 6'h20;
  localparam logic [1:0]  PWR_DEFAULT = 2'h0;
  localparam logic [1:0]  PWR_MODE1   = 2'h2;
  localparam logic [1:0]  PWR_MODE2   = 2'h1;
  localparam logic [1:0]  PWR_MODE3   = 2'h3;
  localparam logic [7:0]  ODI_ADDR    = 8'h41;
  localparam int unsigned ODI_BIT     = 0;
  localparam logic        ODI_RESET   = 1'b0;

  // Sampling-rate thresholds in MSPS: 150, 105, 50
  localparam logic [7:0]  RATE_HI  = 8'h96;
  localparam logic [7:0]  RATE_MID = 8'h69;
  localparam logic [7:0]  RATE_LO  = 8'h32;

  // ------------------------------------------------------------
  // Capture-end register map (AXI4-Lite)
  // ------------------------------------------------------------
  localparam logic [7:0]  REG_CTRL   = 8'h00;
  localparam logic [7:0]  REG_CFG    = 8'h04;
  localparam logic [7:0]  REG_SAMPLE = 8'h08;
  localparam logic [7:0]  REG_STAT   = 8'h0C;
  localparam logic [7:0]  REG_MASK   = 8'h10;
  localparam logic [7:0]  REG_RATE   = 8'h14;
  localparam int unsigned CTRL_CMOS  = 0;
  localparam int unsigned INT_SAMPLE = 0;
  localparam int unsigned INT_OVR    = 1;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_ERR   = 2'h2;
  localparam logic [4:0]  CFG_GAP    = 5'h10;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [6:0] half_bits(input logic [13:0] w, input logic odd);
    logic [6:0] r;
    r = '0;
    for (int i = 0; i < 7; i++) begin
      r[i] = w[2*i + int'(odd)];
    end
    return r;
  endfunction

  function automatic logic [13:0] interleave(input logic [6:0] ev, input logic [6:0] od);
    logic [13:0] r;
    r = '0;
    for (int i = 0; i < 7; i++) begin
      r[2*i]   = ev[i];
      r[2*i+1] = od[i];
    end
    return r;
  endfunction

  function automatic logic [7:0] pwr_byte(input logic [7:0] rate);
    logic [1:0] c;
    c = (rate > RATE_HI) ? PWR_DEFAULT : (rate > RATE_MID) ? PWR_MODE1 :
        (rate > RATE_LO) ? PWR_MODE2 : PWR_MODE3;
    return {c, PWR_FIXED};
  endfunction

endpackage
`default_nettype wire

// File: adp_link_if.sv
// Link between the converter output port and the capture logic
`timescale 1ns/100ps
`default_nettype none
interface adp_link_if;
  logic        output_clock_pos;
  logic        output_clock_neg;
  logic [13:0] data_pos;
  logic [13:0] data_neg;
  logic        over_range;
  logic        out_oe;
  logic        cfg_tgl;
  logic [7:0]  cfg_addr;
  logic [7:0]  cfg_data;

  modport dev  (output output_clock_pos, output_clock_neg, data_pos, data_neg, over_range, out_oe,
                input  cfg_tgl, cfg_addr, cfg_data);
  modport host (input  output_clock_pos, output_clock_neg, data_pos, data_neg, over_range, out_oe,
                output cfg_tgl, cfg_addr, cfg_data);
endinterface
`default_nettype wire

// File: adp_sync.sv
// Two-stage synchroniser for levels arriving from outside the clock domain
`timescale 1ns/100ps
`default_nettype none
module adp_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;
  logic [W-1:0] hold_q;

  // First stage feeds the second stage only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= '0;
      hold_q <= '0;
    end else begin
      meta_q <= d;
      hold_q <= meta_q;
    end
  end

  assign q = hold_q;
endmodule
`default_nettype wire

// File: adp_device.sv
// Converter output port: output clock, DDR or parallel data, over-range and power scaling
`timescale 1ns/100ps
`default_nettype none
module adp_device (
  adp_link_if.dev          link,
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [13:0] sample_data,
  input  wire logic        output_enable_pin,
  input  wire logic        data_format_select_pin,
  output logic             sample_taken,
  output logic [1:0]       power_scale_mode,
  output logic             cmos_active
);

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic [2:0]  pin_s;
  logic        oe_s;
  logic        dfs_s;
  logic        tgl_s;

  adp_sync #(
    .W (3)
  ) u_pin_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       ({output_enable_pin, data_format_select_pin, link.cfg_tgl}),
    .q       (pin_s)
  );

  assign oe_s  = pin_s[2];
  assign dfs_s = pin_s[1];
  assign tgl_s = pin_s[0];

  // ------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------
  logic        tgl_prev_q;
  logic [7:0]  pwr_q;
  logic        odi_q;
  logic        cfg_hit;
  logic        hit_pwr;
  logic        hit_odi;

  // Host holds address and data steady until well after the toggle settles
  assign cfg_hit = tgl_s ^ tgl_prev_q;
  assign hit_pwr = cfg_hit & (link.cfg_addr == adp_pkg::PWR_ADDR);
  assign hit_odi = cfg_hit & (link.cfg_addr == adp_pkg::ODI_ADDR);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tgl_prev_q <= 1'b0;
      pwr_q      <= adp_pkg::PWR_RESET;
      odi_q      <= adp_pkg::ODI_RESET;
    end else begin
      tgl_prev_q <= tgl_s;
      if (hit_pwr) begin
        pwr_q <= link.cfg_data;
      end
      if (hit_odi) begin
        odi_q <= link.cfg_data[adp_pkg::ODI_BIT];
      end
    end
  end

  // ------------------------------------------------------------
  // Output clock divider
  // ------------------------------------------------------------
  logic [2:0]  div_q;
  logic [2:0]  div_d;
  logic        clk_q;
  logic        rise_evt;
  logic        fall_evt;

  assign rise_evt = (div_q == adp_pkg::DIV_LAST);
  assign fall_evt = (div_q == adp_pkg::DIV_FALL);
  assign div_d    = rise_evt ? 3'h0 : div_q + 3'h1;

  // Reset high so the first edge after reset is a real falling edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_q <= 3'h0;
      clk_q <= 1'b1;
    end else begin
      div_q <= div_d;
      if (rise_evt) begin
        clk_q <= 1'b1;
      end else if (fall_evt) begin
        clk_q <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Data path
  // ------------------------------------------------------------
  logic [13:0] word_q;
  logic [13:0] dat_q;
  logic [13:0] dat_d;
  logic [13:0] fall_word;
  logic [13:0] rise_word;
  logic        cmos_q;
  logic        cmos_d;
  logic        over_q;
  logic        over_d;
  logic        taken_q;
  logic        oe_q;

  // Mode is taken only at word boundaries so a change never splits a word
  assign cmos_d    = dfs_s | odi_q;
  assign over_d    = (sample_data == adp_pkg::CODE_MIN) |
                     (sample_data == adp_pkg::CODE_MAX);
  assign fall_word = cmos_d ? sample_data
                            : {7'h00, adp_pkg::half_bits(sample_data, 1'b0)};
  assign rise_word = {7'h00, adp_pkg::half_bits(word_q, 1'b1)};
  assign dat_d     = fall_evt ? fall_word
                   : (rise_evt & ~cmos_q) ? rise_word : dat_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      word_q  <= '0;
      cmos_q  <= 1'b0;
      over_q  <= 1'b0;
      taken_q <= 1'b0;
    end else begin
      taken_q <= fall_evt;
      if (fall_evt) begin
        word_q <= sample_data;
        cmos_q <= cmos_d;
        over_q <= over_d;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dat_q <= '0;
      oe_q  <= 1'b0;
    end else begin
      dat_q <= dat_d;
      oe_q  <= oe_s;
    end
  end

  // ------------------------------------------------------------
  // Pins and status
  // ------------------------------------------------------------
  // Complement lines are only meaningful as pairs in DDR mode
  assign link.output_clock_pos = clk_q;
  assign link.output_clock_neg = ~clk_q;
  assign link.data_pos         = dat_q;
  assign link.data_neg         = ~dat_q;
  assign link.over_range       = over_q;
  assign link.out_oe           = oe_q;

  assign sample_taken     = taken_q;
  assign power_scale_mode = pwr_q[7:6];
  assign cmos_active      = cmos_q;

endmodule
`default_nettype wire

// File: adp_capture.sv
// Capture end: rebuilds samples from the link, drives configuration, AXI4-Lite registers
//
// The register offsets and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module adp_capture (
  adp_link_if.host         link,
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  output logic             irq,
  output logic [13:0]      sample_word,
  output logic             sample_over,
  output logic             sample_strobe
);

  // ------------------------------------------------------------
  // Link capture
  // ------------------------------------------------------------
  logic [16:0] ln_s;
  logic        clk_prev_q;
  logic        rise;
  logic        fall;
  logic        cmos_q;
  logic [6:0]  even_q;
  logic        have_even_q;
  logic        ovr_h_q;
  logic [13:0] smp_q;
  logic        sovr_q;
  logic        sstb_q;

  adp_sync #(
    .W (17)
  ) u_link_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       ({link.out_oe, link.over_range, link.output_clock_pos, link.data_pos}),
    .q       (ln_s)
  );

  // Clock and data share one synchroniser depth, so data seen at an edge is post-edge
  assign rise = ln_s[16] & ln_s[14] & ~clk_prev_q;
  assign fall = ln_s[16] & ~ln_s[14] & clk_prev_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_prev_q  <= 1'b1;
      even_q      <= '0;
      have_even_q <= 1'b0;
      ovr_h_q     <= 1'b0;
      smp_q       <= '0;
      sovr_q      <= 1'b0;
      sstb_q      <= 1'b0;
    end else begin
      clk_prev_q <= ln_s[14];
      sstb_q     <= rise & (cmos_q | have_even_q);
      if (!ln_s[16]) begin
        have_even_q <= 1'b0;
      end else if (fall) begin
        even_q      <= ln_s[6:0];
        ovr_h_q     <= ln_s[15];
        have_even_q <= 1'b1;
      end else if (rise & cmos_q) begin
        smp_q  <= ln_s[13:0];
        sovr_q <= ln_s[15];
      end else if (rise & have_even_q) begin
        smp_q       <= adp_pkg::interleave(even_q, ln_s[6:0]);
        sovr_q      <= ovr_h_q;
        have_even_q <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // AXI4-Lite handshakes
  // ------------------------------------------------------------
  logic        awready_q;
  logic        wready_q;
  logic        bvalid_q;
  logic        arready_q;
  logic        rvalid_q;
  logic [1:0]  bresp_q;
  logic [1:0]  rresp_q;
  logic [31:0] rdata_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        wr_fire;
  logic        ar_hs;

  assign wr_fire = ~awready_q & ~wready_q & ~bvalid_q;
  assign ar_hs   = arvalid & arready_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      bvalid_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= '0;
      wstrb_q   <= '0;
    end else begin
      if (awvalid & awready_q) begin
        awready_q <= 1'b0;
        awaddr_q  <= awaddr;
      end
      if (wvalid & wready_q) begin
        wready_q <= 1'b0;
        wdata_q  <= wdata;
        wstrb_q  <= wstrb;
      end
      if (wr_fire) begin
        bvalid_q <= 1'b1;
      end else if (bvalid_q & bready) begin
        bvalid_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // Register decode
  // ------------------------------------------------------------
  logic [31:0] wmask;
  logic        sel_ctrl;
  logic        sel_cfg;
  logic        sel_stat;
  logic        sel_mask;
  logic        sel_rate;
  logic        cfg_busy;
  logic        launch;
  logic        wr_err;
  logic [7:0]  l_addr;
  logic [7:0]  l_data;
  logic [1:0]  int_set;
  logic [1:0]  stat_q;
  logic [1:0]  mask_q;
  logic [7:0]  rate_q;
  logic [4:0]  gap_q;
  logic        tgl_q;
  logic [7:0]  caddr_q;
  logic [7:0]  cdata_q;
  logic        irq_q;
  logic        rd_known;
  logic [31:0] rd_word;

  assign wmask    = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  assign sel_ctrl = awaddr_q == adp_pkg::REG_CTRL;
  assign sel_cfg  = awaddr_q == adp_pkg::REG_CFG;
  assign sel_stat = awaddr_q == adp_pkg::REG_STAT;
  assign sel_mask = awaddr_q == adp_pkg::REG_MASK;
  assign sel_rate = awaddr_q == adp_pkg::REG_RATE;
  assign cfg_busy = gap_q != 5'h00;
  // A configuration write while one is in flight is refused, not queued
  assign launch   = wr_fire & (sel_cfg | sel_rate) & ~cfg_busy & wstrb_q[0];
  assign wr_err   = ~(sel_ctrl | sel_cfg | sel_stat | sel_mask | sel_rate) |
                    ((sel_cfg | sel_rate) & ~launch);
  assign l_addr   = sel_rate ? adp_pkg::PWR_ADDR : wdata_q[15:8];
  assign l_data   = sel_rate ? adp_pkg::pwr_byte(wdata_q[7:0]) : wdata_q[7:0];
  assign int_set  = {sstb_q & sovr_q, sstb_q};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmos_q  <= 1'b0;
      mask_q  <= '0;
      stat_q  <= '0;
      rate_q  <= '0;
      gap_q   <= '0;
      tgl_q   <= 1'b0;
      caddr_q <= '0;
      cdata_q <= '0;
      bresp_q <= adp_pkg::RESP_OKAY;
      irq_q   <= 1'b0;
    end else begin
      irq_q <= |(stat_q & mask_q);
      // A new event wins over a clear in the same cycle
      stat_q <= (stat_q & ~((wr_fire & sel_stat) ? (wdata_q[1:0] & wmask[1:0]) : 2'h0)) | int_set;
      gap_q  <= launch ? adp_pkg::CFG_GAP : (cfg_busy ? gap_q - 5'h01 : gap_q);
      if (wr_fire) begin
        bresp_q <= wr_err ? adp_pkg::RESP_ERR : adp_pkg::RESP_OKAY;
        if (sel_ctrl & wstrb_q[0]) cmos_q <= wdata_q[adp_pkg::CTRL_CMOS];
        if (sel_mask & wstrb_q[0]) mask_q <= wdata_q[1:0];
        if (sel_rate & launch) rate_q <= wdata_q[7:0];
      end
      if (launch) begin
        tgl_q   <= ~tgl_q;
        caddr_q <= l_addr;
        cdata_q <= l_data;
      end
    end
  end

  assign rd_known = (araddr == adp_pkg::REG_CTRL) | (araddr == adp_pkg::REG_CFG) |
                    (araddr == adp_pkg::REG_SAMPLE) | (araddr == adp_pkg::REG_STAT) |
                    (araddr == adp_pkg::REG_MASK) | (araddr == adp_pkg::REG_RATE);
  assign rd_word  = (araddr == adp_pkg::REG_CTRL)   ? {31'h0, cmos_q} :
                    (araddr == adp_pkg::REG_CFG)    ? {15'h0, cfg_busy, caddr_q, cdata_q} :
                    (araddr == adp_pkg::REG_SAMPLE) ? {17'h0, sovr_q, smp_q} :
                    (araddr == adp_pkg::REG_STAT)   ? {30'h0, stat_q} :
                    (araddr == adp_pkg::REG_MASK)   ? {30'h0, mask_q} :
                    (araddr == adp_pkg::REG_RATE)   ? {24'h0, rate_q} : 32'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= '0;
      rresp_q   <= adp_pkg::RESP_OKAY;
    end else if (ar_hs) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rdata_q   <= rd_word;
      rresp_q   <= rd_known ? adp_pkg::RESP_OKAY : adp_pkg::RESP_ERR;
    end else if (rvalid_q & rready) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign awready       = awready_q;
  assign wready        = wready_q;
  assign bvalid        = bvalid_q;
  assign bresp         = bresp_q;
  assign arready       = arready_q;
  assign rvalid        = rvalid_q;
  assign rdata         = rdata_q;
  assign rresp         = rresp_q;
  assign irq           = irq_q;
  assign sample_word   = smp_q;
  assign sample_over   = sovr_q;
  assign sample_strobe = sstb_q;
  assign link.cfg_tgl  = tgl_q;
  assign link.cfg_addr = caddr_q;
  assign link.cfg_data = cdata_q;

endmodule
`default_nettype wire

// File: adp_link_monitor.sv
// Concurrent checks on the link between converter port and capture end
`timescale 1ns/100ps
`default_nettype none
module adp_link_monitor (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        output_clock_pos,
  input wire logic        output_clock_neg,
  input wire logic [13:0] data_pos,
  input wire logic [13:0] data_neg,
  input wire logic        over_range,
  input wire logic        out_oe,
  input wire logic        cfg_tgl,
  input wire logic [7:0]  cfg_addr,
  input wire logic [7:0]  cfg_data
);
  // ------------------------------------------------------------
  // Link checks
  // ------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Floating outputs carry no meaning, so the three edge-timing checks need two driven cycles
  a_clk_pair_compl: assert property (out_oe |-> output_clock_neg == ~output_clock_pos)
    else $error("output clock pair not complementary");
  a_data_pair_compl: assert property (out_oe |-> data_neg == ~data_pos)
    else $error("data pairs not complementary");
  a_clk_low_half: assert property (out_oe && $past(out_oe) && $fell(output_clock_pos) |->
    ##1 (!output_clock_pos)[*3] ##1 output_clock_pos)
    else $error("output clock low phase not four cycles");
  a_data_on_edge: assert property (out_oe && $past(out_oe) && $changed(data_pos) |->
    $changed(output_clock_pos))
    else $error("data moved away from an output clock edge");
  a_over_on_fall: assert property (out_oe && $past(out_oe) && $changed(over_range) |->
    $fell(output_clock_pos))
    else $error("over-range moved away from a falling edge");
  a_cfg_held: assert property ($stable(cfg_tgl) |-> $stable(cfg_addr) && $stable(cfg_data))
    else $error("config byte changed without a toggle");
  a_cfg_spacing: assert property ($changed(cfg_tgl) |=>
    $stable(cfg_tgl)[*8] ##1 $stable(cfg_tgl)[*7])
    else $error("config toggles closer than sixteen cycles");
  a_reset_idle: assert property ($rose(aresetn) |-> !out_oe && output_clock_pos && !cfg_tgl)
    else $error("link not idle during reset");

  c_cfg_sent: cover property ($changed(cfg_tgl));
  c_oe_off: cover property ($fell(out_oe));
  c_over_seen: cover property (out_oe && over_range);
endmodule
`default_nettype wire

// File: adc_ddr_output_port_bench.sv
// Testbench joining converter port and capture end across the link
`timescale 1ns/100ps
`default_nettype none
module adc_ddr_output_port_bench;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [13:0] sample_data = 14'h0000;
  logic        output_enable_pin = 1'b1;
  logic        data_format_select_pin = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0]  wstrb = 4'hF;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, irq, sample_over, sample_strobe;
  logic        sample_taken, cmos_active;
  logic [1:0]  bresp, rresp, power_scale_mode, rs;
  logic [31:0] rdata, rd;
  logic [13:0] sample_word;
  int          failures = 0;
  int          samples_checked = 0;
  logic [13:0] vals [4] = '{14'h0000, 14'h3FFF, 14'h2AAA, 14'h1555};
  logic [7:0]  rates [6] = '{8'hC8, 8'h96, 8'h6A, 8'h69, 8'h33, 8'h32};
  logic [1:0]  modes [6] = '{adp_pkg::PWR_DEFAULT, adp_pkg::PWR_MODE1, adp_pkg::PWR_MODE1,
                             adp_pkg::PWR_MODE2, adp_pkg::PWR_MODE2, adp_pkg::PWR_MODE3};

  adp_link_if link ();
  adp_device u_adp_device (.link(link), .aclk(aclk), .aresetn(aresetn), .sample_data(sample_data),
    .output_enable_pin(output_enable_pin), .data_format_select_pin(data_format_select_pin),
    .sample_taken(sample_taken), .power_scale_mode(power_scale_mode), .cmos_active(cmos_active));
  adp_capture u_adp_capture (.link(link), .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .irq(irq), .sample_word(sample_word), .sample_over(sample_over),
    .sample_strobe(sample_strobe));
  adp_link_monitor u_adp_link_monitor (.aclk(aclk), .aresetn(aresetn), .output_clock_pos(link.output_clock_pos),
    .output_clock_neg(link.output_clock_neg), .data_pos(link.data_pos), .data_neg(link.data_neg),
    .over_range(link.over_range), .out_oe(link.out_oe), .cfg_tgl(link.cfg_tgl),
    .cfg_addr(link.cfg_addr), .cfg_data(link.cfg_data));

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  initial begin
    forever #50 aclk = ~aclk;
  end

  task automatic give_verdict();
    if (failures == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", what, exp, got);
      failures++;
    end
  endtask

  task automatic hung(input int n);
    if (n >= 60) begin
      $display("Error wait expected 1 seen 0");
      failures++;
      give_verdict();
    end
  endtask

  // Address and data are offered together and each is dropped once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      n++;
    end while (!bvalid && n < 60);
    hung(n);
    bready <= 1'b0;
    rd = {30'h0000_0000, bresp};
    @(posedge aclk);
  endtask

  task automatic axi_rd(input logic [7:0] a);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      n++;
    end while (!rvalid && n < 60);
    hung(n);
    rready <= 1'b0;
    rd = rdata;
    rs = rresp;
    @(posedge aclk);
  endtask

  task automatic wait_strobes(input int k);
    int n;
    repeat (k) begin
      n = 0;
      do begin
        @(posedge aclk);
        n++;
      end while (!sample_strobe && n < 60);
      hung(n);
    end
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_power();
    foreach (rates[i]) begin
      axi_wr(adp_pkg::REG_RATE, {24'h00_0000, rates[i]});
      chk("bresp", adp_pkg::RESP_OKAY, rd);
      // A second order while the link is busy must be refused
      if (i == 0) axi_wr(adp_pkg::REG_RATE, 32'h0000_0032);
      if (i == 0) chk("busy bresp", adp_pkg::RESP_ERR, rd);
      repeat (20) @(posedge aclk);
      chk("power_scale_mode", modes[i], power_scale_mode);
    end
  endtask

  // Parallel mode comes either from the pin or from the device's own select bit
  task automatic t_words(input logic par, input logic via_reg);
    data_format_select_pin <= par & ~via_reg;
    if (via_reg) begin
      axi_wr(adp_pkg::REG_CFG, {16'h0000, adp_pkg::ODI_ADDR, 7'h00, par});
      chk("odi bresp", adp_pkg::RESP_OKAY, rd);
    end
    axi_wr(adp_pkg::REG_CTRL, {31'h0000_0000, par});
    foreach (vals[i]) begin
      sample_data <= vals[i];
      // The first strobes may still carry the previous word
      wait_strobes(3);
      chk("sample_word", vals[i], sample_word);
      chk("sample_over", vals[i] == adp_pkg::CODE_MIN || vals[i] == adp_pkg::CODE_MAX, sample_over);
      chk("cmos_active", par, cmos_active);
      axi_rd(adp_pkg::REG_SAMPLE);
      chk("sample reg", {sample_over, vals[i]}, rd[14:0]);
    end
  endtask

  task automatic t_disable();
    int cnt;
    int taken;
    cnt = 0;
    taken = 0;
    output_enable_pin <= 1'b0;
    repeat (8) @(posedge aclk);
    chk("out_oe", 1'b0, link.out_oe);
    repeat (24) begin
      @(posedge aclk);
      if (sample_strobe) cnt++;
      if (sample_taken) taken++;
    end
    chk("strobes while off", 0, cnt);
    chk("sample_taken pulses", 3, taken);
    output_enable_pin <= 1'b1;
    wait_strobes(2);
  endtask

  // Over-range bit is cleared first so that only a fresh full-scale sample can raise irq
  task automatic t_irq();
    axi_wr(adp_pkg::REG_MASK, 32'h0000_0002);
    axi_wr(adp_pkg::REG_STAT, 32'h0000_0003);
    repeat (2) @(posedge aclk);
    chk("irq clear", 1'b0, irq);
    sample_data <= adp_pkg::CODE_MAX;
    wait_strobes(3);
    repeat (2) @(posedge aclk);
    chk("irq on", 1'b1, irq);
    axi_rd(adp_pkg::REG_STAT);
    chk("stat bits", 2'h3, rd[1:0]);
    axi_wr(adp_pkg::REG_MASK, 32'h0000_0000);
    repeat (2) @(posedge aclk);
    chk("irq masked", 1'b0, irq);
    axi_rd(8'h3C);
    chk("unmapped rresp", adp_pkg::RESP_ERR, rs);
    axi_wr(adp_pkg::REG_SAMPLE, 32'h0000_0000);
    chk("ro bresp", adp_pkg::RESP_ERR, rd);
  endtask

  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("reset mode", adp_pkg::PWR_DEFAULT, power_scale_mode);
    t_power();
    t_words(1'b0, 1'b0);
    t_words(1'b1, 1'b0);
    t_words(1'b0, 1'b0);
    t_words(1'b1, 1'b1);
    t_words(1'b0, 1'b1);
    t_disable();
    t_irq();
    give_verdict();
  end
endmodule
`default_nettype wire
